// file: core/dmb_pkg.sv
// Constants for the mode word decoder and burst column sequencer.
// Assumes a single 10 MHz clock domain; no import, use dmb_pkg::name.
package dmb_pkg;
  // ****************************************
  // Bus widths
  // ****************************************
  localparam int ADDR_W  = 13;
  localparam int BANK_W  = 2;
  localparam int COL_W   = 3;
  // ****************************************
  // Bank codes selecting a word
  // ****************************************
  localparam logic [1:0] BANK_MODE_WORD = 2'h0;
  localparam logic [1:0] BANK_EXT_ONE   = 2'h1;
  // ****************************************
  // Operating mode word field positions
  // ****************************************
  localparam int BL_LO  = 0;
  localparam int BL_HI  = 2;
  localparam int BT_BIT = 3;
  localparam int CL_LO  = 4;
  localparam int CL_HI  = 6;
  localparam int TM_BIT = 7;
  localparam int DR_BIT = 8;
  localparam int WR_LO  = 9;
  localparam int WR_HI  = 11;
  localparam int PD_BIT = 12;
  // ****************************************
  // Field codes
  // ****************************************
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_MIN = 3'h3;
  localparam logic [2:0] CL_CODE_MAX = 3'h6;
  localparam logic [2:0] WR_CODE_MIN = 3'h1;
  localparam logic [2:0] WR_CODE_MAX = 3'h5;
  localparam logic [2:0] WR_CODE_OFFSET = 3'h1;
  localparam logic [3:0] BEATS_4 = 4'h4;
  localparam logic [3:0] BEATS_8 = 4'h8;
  // ****************************************
  // First extended word fields
  // ****************************************
  localparam int EXT_DLL_DIS_BIT = 0;
  localparam int EXT_READ_STROBE_COPY_BIT    = 11;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int MRD_GAP_CYC   = 2;
  localparam logic [1:0] MRD_GAP = 2'(MRD_GAP_CYC);
  localparam int DLL_LOCK_CYC  = 200;
  localparam logic [7:0] DLL_LOCK = 8'(DLL_LOCK_CYC);
  // ****************************************
  // Load gap states
  // ****************************************
  typedef enum logic [1:0] {DMB_IDLE, DMB_GAP} dmb_gap_t;
endpackage : dmb_pkg

// file: core/dmb_cmd_sync.sv
// Two-flop synchroniser for the command and address pins.
// Assumes pins change relative to CLK_IN only at command boundaries.
`timescale 1ns/1ps
`default_nettype none
module dmb_cmd_sync #(
  parameter int W = 20
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  // ****************************************
  // First stage read only by second stage
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff <= '0;
      q_out   <= '0;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end
endmodule : dmb_cmd_sync
`default_nettype wire

// file: core/dmb_col_order.sv
// Column offset generator for one burst beat.
// Assumes start offset and index are stable in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module dmb_col_order (
  input  wire logic [2:0] start_in,
  input  wire logic [2:0] index_in,
  input  wire logic       interleave_in,
  input  wire logic       long_burst_in,
  output logic      [2:0] col_out
);
  logic [1:0] seq_lo;
  logic       hi_bit;
  // Sequential: wrap within group of four
  assign seq_lo = 2'(start_in[1:0] + index_in[1:0]);
  // Upper bit flips in second group, only in long bursts
  assign hi_bit = start_in[2] ^ (long_burst_in & index_in[2]);
  // Interleaved: index xor start; else nibble wrap
  always_comb begin
    if (interleave_in) begin
      col_out = start_in ^ {long_burst_in & index_in[2], index_in[1:0]};
    end else begin
      col_out = {hi_bit, seq_lo};
    end
  end
endmodule : dmb_col_order
`default_nettype wire

// file: core/dmb_mode_core.sv
// Mode word decoder and burst column sequencer of the memory device.
// Assumes the controller keeps command spacing and precharge state.
`timescale 1ns/1ps
`default_nettype none
module dmb_mode_core (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CKE_IN,
  input  wire logic        CS_N_IN,
  input  wire logic        RAS_N_IN,
  input  wire logic        CAS_N_IN,
  input  wire logic        WE_N_IN,
  input  wire logic [1:0]  BA_IN,
  input  wire logic [12:0] ADDR_IN,
  output logic      [3:0]  BURST_BEATS_OUT,
  output logic             INTERLEAVE_OUT,
  output logic      [2:0]  CAS_LATENCY_OUT,
  output logic      [2:0]  WRITE_RECOVERY_OUT,
  output logic             TEST_MODE_OUT,
  output logic             SLOW_EXIT_OUT,
  output logic             DLL_RESET_OUT,
  output logic             DLL_READY_OUT,
  output logic             MODE_VALID_OUT,
  output logic             EXT_VALID_OUT,
  output logic      [12:0] EXT_WORD_OUT,
  output logic             CFG_ERROR_OUT,
  output logic             GAP_BUSY_OUT,
  output logic             BURST_ACTIVE_OUT,
  output logic             BURST_WRITE_OUT,
  output logic      [2:0]  COLUMN_OFFSET_OUT,
  output logic             ILLEGAL_CMD_OUT
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  localparam int SYNC_W = 5 + dmb_pkg::BANK_W + dmb_pkg::ADDR_W;
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_sync;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [1:0]        ba;
  logic [12:0]       addr;

  // Pack pins for the synchroniser
  assign pins_raw = {CKE_IN, CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN, BA_IN, ADDR_IN};

  dmb_cmd_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     (pins_raw),
    .q_out    (pins_sync)
  );

  // Unpack synchronised pins
  assign {cke, cs_n, ras_n, cas_n, we_n, ba, addr} = pins_sync;

  // ****************************************
  // Command decode
  // ****************************************
  logic cmd_valid;
  logic cmd_load;
  logic cmd_read;
  logic cmd_write;
  logic cmd_term;
  logic load_mode;
  logic load_ext;

  // Command only counts with clock enabled and chip selected
  assign cmd_valid = cke & ~cs_n;
  assign cmd_load  = cmd_valid & ~ras_n & ~cas_n & ~we_n;
  assign cmd_read  = cmd_valid & ras_n & ~cas_n & we_n;
  assign cmd_write = cmd_valid & ras_n & ~cas_n & ~we_n;
  // Old stop encoding is only flagged as illegal inside a burst
  assign cmd_term  = cmd_valid & ras_n & cas_n & ~we_n;
  assign load_mode = cmd_load & (ba == dmb_pkg::BANK_MODE_WORD);
  assign load_ext  = cmd_load & (ba == dmb_pkg::BANK_EXT_ONE);

  // ****************************************
  // Staged mode word and gap
  // ****************************************
  logic [12:0]       staged_ff;
  logic              staged_pend_ff;
  logic [12:0]       mode_ff;
  logic              mode_valid_ff;
  logic [12:0]       ext_ff;
  logic              ext_valid_ff;
  logic [1:0]        gap_cnt_ff;
  dmb_pkg::dmb_gap_t gap_state_ff;

  // Capture written word, hold it back during gap
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      staged_ff      <= '0;
      staged_pend_ff <= 1'b0;
    end else if (load_mode) begin
      staged_ff      <= addr;
      staged_pend_ff <= 1'b1;
    end else if (gap_state_ff == dmb_pkg::DMB_GAP && gap_cnt_ff == 2'h1) begin
      staged_pend_ff <= 1'b0;
    end
  end

  // Gap counter after a mode or first extended word load
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      gap_state_ff <= dmb_pkg::DMB_IDLE;
      gap_cnt_ff   <= '0;
    end else begin
      case (gap_state_ff)
        dmb_pkg::DMB_IDLE: begin
          if (load_mode | load_ext) begin
            gap_state_ff <= dmb_pkg::DMB_GAP;
            gap_cnt_ff   <= dmb_pkg::MRD_GAP;
          end
        end
        dmb_pkg::DMB_GAP: begin
          if (load_mode | load_ext) begin
            gap_cnt_ff <= dmb_pkg::MRD_GAP;
          end else if (gap_cnt_ff == 2'h1) begin
            gap_state_ff <= dmb_pkg::DMB_IDLE;
            gap_cnt_ff   <= '0;
          end else begin
            gap_cnt_ff <= 2'(gap_cnt_ff - 2'h1);
          end
        end
        default: begin
          gap_state_ff <= dmb_pkg::DMB_IDLE;
          gap_cnt_ff   <= '0;
        end
      endcase
    end
  end

  // Apply staged word once gap has elapsed
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_ff       <= '0;
      mode_valid_ff <= 1'b0;
    end else if (staged_pend_ff && gap_state_ff == dmb_pkg::DMB_GAP && gap_cnt_ff == 2'h1 && !load_mode) begin
      mode_ff       <= staged_ff;
      mode_valid_ff <= 1'b1;
    end
  end

  // First extended word, kept whole for other blocks
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ext_ff       <= '0;
      ext_valid_ff <= 1'b0;
    end else if (load_ext) begin
      ext_ff       <= addr;
      ext_valid_ff <= 1'b1;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  logic [2:0] bl_code;
  logic [2:0] cl_code;
  logic [2:0] wr_code;
  logic       bl_ok;
  logic       cl_ok;
  logic       wr_ok;

  assign bl_code = mode_ff[dmb_pkg::BL_HI:dmb_pkg::BL_LO];
  assign cl_code = mode_ff[dmb_pkg::CL_HI:dmb_pkg::CL_LO];
  assign wr_code = mode_ff[dmb_pkg::WR_HI:dmb_pkg::WR_LO];
  assign bl_ok   = (bl_code == dmb_pkg::BL_CODE_4) | (bl_code == dmb_pkg::BL_CODE_8);
  // Integer codes only; latency equals code
  assign cl_ok   = (cl_code >= dmb_pkg::CL_CODE_MIN) & (cl_code <= dmb_pkg::CL_CODE_MAX);
  assign wr_ok   = (wr_code >= dmb_pkg::WR_CODE_MIN) & (wr_code <= dmb_pkg::WR_CODE_MAX);

  // ****************************************
  // Field output timing
  // ****************************************
  // The decoded fields leave through one register
  // stage, so the valid flag rides that same stage.
  // An observer then never sees the valid flag high
  // beside the fields of the previous word.
  // The burst beat count idles at four out of reset,
  // the same as a cleared word decodes to, so the
  // output never shows a count the device lacks.
  // Reserved codes still decode to a known value:
  // four beats, zero latency, zero recovery, plus the
  // configuration error flag for the controller.
  // The test bit is passed on as written; keeping it
  // clear is the controller's duty, not ours.

  // Registered field outputs
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      BURST_BEATS_OUT    <= dmb_pkg::BEATS_4;
      MODE_VALID_OUT     <= 1'b0;
      INTERLEAVE_OUT     <= 1'b0;
      CAS_LATENCY_OUT    <= '0;
      WRITE_RECOVERY_OUT <= '0;
      TEST_MODE_OUT      <= 1'b0;
      SLOW_EXIT_OUT      <= 1'b0;
      CFG_ERROR_OUT      <= 1'b0;
    end else begin
      BURST_BEATS_OUT    <= (bl_code == dmb_pkg::BL_CODE_8) ? dmb_pkg::BEATS_8 : dmb_pkg::BEATS_4;
      INTERLEAVE_OUT     <= mode_ff[dmb_pkg::BT_BIT];
      CAS_LATENCY_OUT    <= cl_ok ? cl_code : '0;
      WRITE_RECOVERY_OUT <= wr_ok ? 3'(wr_code + dmb_pkg::WR_CODE_OFFSET) : '0;
      TEST_MODE_OUT      <= mode_ff[dmb_pkg::TM_BIT];
      SLOW_EXIT_OUT      <= mode_ff[dmb_pkg::PD_BIT];
      CFG_ERROR_OUT      <= mode_valid_ff & ~(bl_ok & cl_ok & wr_ok);
      MODE_VALID_OUT     <= mode_valid_ff;
    end
  end

  // ****************************************
  // Loop reset and lock wait
  // ****************************************
  logic [7:0] lock_cnt_ff;
  logic       dll_reset_ff;

  // Pulse reset when written bit eight is set
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dll_reset_ff <= 1'b0;
      lock_cnt_ff  <= '0;
    end else begin
      dll_reset_ff <= load_mode & addr[dmb_pkg::DR_BIT];
      if (load_mode & addr[dmb_pkg::DR_BIT]) begin
        lock_cnt_ff <= dmb_pkg::DLL_LOCK;
      end else if (lock_cnt_ff != '0) begin
        lock_cnt_ff <= 8'(lock_cnt_ff - 8'h01);
      end
    end
  end

  assign DLL_RESET_OUT = dll_reset_ff;
  // Ready once enabled and lock time spent
  assign DLL_READY_OUT = ext_valid_ff & ~ext_ff[dmb_pkg::EXT_DLL_DIS_BIT] & (lock_cnt_ff == '0);

  // ****************************************
  // Burst sequencer
  // ****************************************
  // One beat per clock; the offset output trails the
  // beat index by one register stage.
  // A read or write of either type on the last beat
  // chains the next burst with no idle beat between them.
  // Forbidden cuts are flagged; a forbidden read,
  // write or stop is ignored, so the running burst
  // completes its full length unless a legal
  // same-type cut in a long burst restarts it, but a
  // flagged mode or extended word load still applies.
  logic       burst_act_ff;
  logic       burst_wr_ff;
  logic [2:0] start_ff;
  logic [2:0] index_ff;
  logic       long_burst;
  logic [2:0] last_index;
  logic       interrupt_ok;
  logic       col_cmd;
  logic [2:0] col_next;
  logic       illegal_ff;

  assign long_burst   = (BURST_BEATS_OUT == dmb_pkg::BEATS_8);
  assign last_index   = long_burst ? 3'h7 : 3'h3;
  assign col_cmd      = cmd_read | cmd_write;
  // Same type may cut in only in long bursts
  assign interrupt_ok = long_burst & (cmd_write == burst_wr_ff);

  // Start, advance and chain bursts
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      burst_act_ff <= 1'b0;
      burst_wr_ff  <= 1'b0;
      start_ff     <= '0;
      index_ff     <= '0;
    end else if (col_cmd && (!burst_act_ff || index_ff == last_index || interrupt_ok)) begin
      burst_act_ff <= 1'b1;
      burst_wr_ff  <= cmd_write;
      start_ff     <= long_burst ? addr[2:0] : {1'b0, addr[1:0]};
      index_ff     <= '0;
    end else if (burst_act_ff) begin
      if (index_ff == last_index) begin
        burst_act_ff <= 1'b0;
        index_ff     <= '0;
      end else begin
        index_ff <= 3'(index_ff + 3'h1);
      end
    end
  end

  // Flag commands that cut a burst illegally
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= burst_act_ff & (index_ff != last_index) & ((col_cmd & ~interrupt_ok) | cmd_term | cmd_load);
    end
  end

  dmb_col_order u_order (
    .start_in      (start_ff),
    .index_in      (index_ff),
    .interleave_in (INTERLEAVE_OUT),
    .long_burst_in (long_burst),
    .col_out       (col_next)
  );

  // Registered column offset
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      COLUMN_OFFSET_OUT <= '0;
    end else begin
      COLUMN_OFFSET_OUT <= col_next;
    end
  end

  assign BURST_ACTIVE_OUT = burst_act_ff;
  assign BURST_WRITE_OUT  = burst_wr_ff;
  assign ILLEGAL_CMD_OUT  = illegal_ff;
  assign EXT_VALID_OUT    = ext_valid_ff;
  assign EXT_WORD_OUT     = ext_ff;
  assign GAP_BUSY_OUT     = (gap_state_ff == dmb_pkg::DMB_GAP);
endmodule : dmb_mode_core
`default_nettype wire

// file: verif/dmb_mode_props.sv
// Port checks for the mode word decoder and burst sequencer.
// Assumes binding onto dmb_mode_core; one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none
module dmb_mode_props (
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        CS_N_IN,
  input wire logic        RAS_N_IN,
  input wire logic        CAS_N_IN,
  input wire logic        WE_N_IN,
  input wire logic [1:0]  BA_IN,
  input wire logic [3:0]  BURST_BEATS_OUT,
  input wire logic        INTERLEAVE_OUT,
  input wire logic [2:0]  CAS_LATENCY_OUT,
  input wire logic [2:0]  WRITE_RECOVERY_OUT,
  input wire logic        DLL_RESET_OUT,
  input wire logic        DLL_READY_OUT,
  input wire logic        MODE_VALID_OUT,
  input wire logic        CFG_ERROR_OUT,
  input wire logic        GAP_BUSY_OUT,
  input wire logic        BURST_ACTIVE_OUT,
  input wire logic        ILLEGAL_CMD_OUT
);
  // ********************
  // Port relations
  // ********************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Mode load present at the pins
  logic load_seen;
  assign load_seen = !CS_N_IN && !RAS_N_IN && !CAS_N_IN && !WE_N_IN && BA_IN == dmb_pkg::BANK_MODE_WORD;
  load_gap_a: assert property (load_seen |-> ##[1:4] GAP_BUSY_OUT)
    else $error("mode load did not start the gap");
  beats_legal_a: assert property (BURST_BEATS_OUT == 4'h4 || BURST_BEATS_OUT == 4'h8)
    else $error("burst beats not four or eight");
  cas_legal_a: assert property (CAS_LATENCY_OUT == 3'h0 || (CAS_LATENCY_OUT >= 3'h3 && CAS_LATENCY_OUT <= 3'h6))
    else $error("cas latency out of range");
  wr_legal_a: assert property (WRITE_RECOVERY_OUT == 3'h0 || WRITE_RECOVERY_OUT >= 3'h2)
    else $error("write recovery out of range");
  cfg_flag_a: assert property (MODE_VALID_OUT && (CAS_LATENCY_OUT == 3'h0 || WRITE_RECOVERY_OUT == 3'h0) |->
    ##[0:1] CFG_ERROR_OUT) else $error("reserved code not flagged");
  dll_pulse_a: assert property (DLL_RESET_OUT |=> !DLL_RESET_OUT)
    else $error("loop reset longer than one cycle");
  lock_wait_a: assert property (DLL_RESET_OUT |-> ##2 (!DLL_READY_OUT) [*8])
    else $error("loop ready too soon after reset");
  field_hold_a: assert property ($changed(INTERLEAVE_OUT) |-> $past(GAP_BUSY_OUT, 2)
    || $past(GAP_BUSY_OUT, 3) || $past(GAP_BUSY_OUT, 4)) else $error("field changed without load");
  burst_min_a: assert property ($rose(BURST_ACTIVE_OUT) |-> BURST_ACTIVE_OUT [*4])
    else $error("burst shorter than four beats");
  illegal_ctx_a: assert property (ILLEGAL_CMD_OUT |-> BURST_ACTIVE_OUT || $past(BURST_ACTIVE_OUT))
    else $error("illegal flag outside a burst");
  // Main scenarios reached
  cover property (DLL_RESET_OUT);
  cover property (ILLEGAL_CMD_OUT);
  cover property (CFG_ERROR_OUT);
  cover property ($rose(BURST_ACTIVE_OUT) && INTERLEAVE_OUT);
endmodule : dmb_mode_props
bind dmb_mode_core dmb_mode_props u_props (.*);
`default_nettype wire

// file: verif/dmb_ctl_model.sv
// Memory controller model driving the command and address pins.
// Assumes callers keep banks precharged; tasks end on a clock edge.
`timescale 1ns/1ps
`default_nettype none
module dmb_ctl_model (
  input  wire logic        clk_in,
  output logic             cke_out,
  output logic             cs_n_out,
  output logic             ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic      [1:0]  ba_out,
  output logic      [12:0] addr_out
);
  // ********************
  // Pin driving
  // ********************
  // Clock enable high before any load
  initial begin
    cke_out = 1'b1;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
    ba_out = 2'h0;
    addr_out = 13'h0000;
  end
  // One command cycle, then deselect with scrambled lines
  task cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(posedge clk_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= c;
    ba_out <= b;
    addr_out <= a;
    @(posedge clk_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= ~c | 4'h8;
    ba_out <= ~b;
    addr_out <= ~a;
  endtask : cmd
  // Mode load, then idle past the gap
  task mode_write(input logic [12:0] w);
    cmd(4'h0, dmb_pkg::BANK_MODE_WORD, w);
    repeat (dmb_pkg::MRD_GAP_CYC + 6) @(posedge clk_in);
  endtask : mode_write
  // Extended load with the strobe copy bit kept clear
  task ext_write(input logic [12:0] w);
    cmd(4'h0, dmb_pkg::BANK_EXT_ONE, w & ~(13'h0001 << dmb_pkg::EXT_READ_STROBE_COPY_BIT));
    repeat (dmb_pkg::MRD_GAP_CYC + 6) @(posedge clk_in);
  endtask : ext_write
  // Column read or write at a start offset
  task col_cmd(input logic w, input logic [2:0] s);
    cmd({3'h2, ~w}, 2'h0, {10'h000, s});
  endtask : col_cmd
endmodule : dmb_ctl_model
`default_nettype wire

// file: verif/tb_ddr2_mode_register_burst_order.sv
// Self-checking bench for the mode decoder and burst sequencer.
// Assumes dmb_ctl_model drives the pins; checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_mode_register_burst_order;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        cke, cs_n, ras_n, cas_n, we_n, ilv, tm, slow, dll_rst, dll_rdy;
  logic        mval, evld, cerr, gbusy, bact, bwr, illg;
  logic [1:0]  ba;
  logic [12:0] addr, eword;
  logic [3:0]  beats;
  logic [2:0]  cl, wr, col;
  int          n_errors = 0;
  int          compares = 0;
  int          n_pulse = 0;
  int          n_ill = 0;
  // 10 MHz clock
  always #50 clk_in = ~clk_in;
  dmb_mode_core dut (.CLK_IN(clk_in), .RST_N_IN(rst_n_in), .CKE_IN(cke), .CS_N_IN(cs_n),
    .RAS_N_IN(ras_n), .CAS_N_IN(cas_n), .WE_N_IN(we_n), .BA_IN(ba), .ADDR_IN(addr),
    .BURST_BEATS_OUT(beats), .INTERLEAVE_OUT(ilv), .CAS_LATENCY_OUT(cl), .WRITE_RECOVERY_OUT(wr),
    .TEST_MODE_OUT(tm), .SLOW_EXIT_OUT(slow), .DLL_RESET_OUT(dll_rst), .DLL_READY_OUT(dll_rdy),
    .MODE_VALID_OUT(mval), .EXT_VALID_OUT(evld), .EXT_WORD_OUT(eword), .CFG_ERROR_OUT(cerr),
    .GAP_BUSY_OUT(gbusy), .BURST_ACTIVE_OUT(bact), .BURST_WRITE_OUT(bwr),
    .COLUMN_OFFSET_OUT(col), .ILLEGAL_CMD_OUT(illg));
  dmb_ctl_model ctl (.clk_in(clk_in), .cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n),
    .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba), .addr_out(addr));
  // ********************
  // Helpers
  // ********************
  // Pulse counters
  always @(posedge clk_in) begin
    if (dll_rst === 1'b1) n_pulse++;
    if (illg === 1'b1) n_ill++;
  end
  task chk(input logic [12:0] seen, input logic [12:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick;
    @(posedge clk_in);
    #1;
  endtask : tick
  task close_out;
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // Load a mode word and compare every field except the loop reset bit
  task fields(input logic [12:0] w, input logic [3:0] eb, input logic [2:0] ec, input logic [2:0] ewr,
              input logic eerr);
    ctl.mode_write(w);
    #1;
    chk(beats, eb);
    chk(ilv, w[3]);
    chk(cl, ec);
    chk(wr, ewr);
    chk(slow, w[12]);
    chk(tm, w[7]);
    chk(cerr, eerr);
    chk(mval, 1'b1);
  endtask : fields
  // Program a burst mode, run one burst, compare each offset
  task burst(input logic [2:0] s, input int n, input logic il, input logic w);
    logic [2:0] e;
    int         k;
    ctl.mode_write({1'b0, 3'h1, 2'h0, 3'h3, il, (n == 8) ? 3'h3 : 3'h2});
    ctl.col_cmd(w, s);
    for (k = 0; k < 20 && bact !== 1'b1; k++) tick;
    chk(bact, 1'b1);
    if (bact !== 1'b1) close_out;
    chk(bwr, w);
    for (k = 0; k < n; k++) begin
      tick;
      e = il ? (3'(k) ^ s) : {s[2] ^ 1'(k >> 2), s[1:0] + 2'(k)};
      if (n == 4) chk(col[1:0], e[1:0]);
      else chk(col, e);
    end
    repeat (4) tick;
  endtask : burst
  // ********************
  // Test sequence
  // ********************
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    tick;
    chk(mval, 1'b0);
    chk(evld, 1'b0);
    ctl.ext_write(13'h0002);
    #1;
    chk(eword, 13'h0002);
    chk(evld, 1'b1);
    ctl.cmd(4'h0, 2'h2, 13'h1fff);
    repeat (8) tick;
    chk(eword, 13'h0002);
    chk(mval, 1'b0);
    for (int i = 0; i < 5; i++) begin
      fields({i[0], 3'(i + 1), 2'h0, 3'(3 + (i & 3)), i[0], i[1] ? 3'h3 : 3'h2},
             i[1] ? 4'h8 : 4'h4, 3'(3 + (i & 3)), 3'(i + 2), 1'b0);
    end
    fields({1'b0, 3'h0, 1'b0, 1'b1, 3'h7, 1'b0, 3'h6}, 4'h4, 3'h0, 3'h0, 1'b1);
    fields({1'b1, 3'h6, 2'h0, 3'h2, 1'b1, 3'h2}, 4'h4, 3'h0, 3'h0, 1'b1);
    chk(n_pulse, 0);
    ctl.mode_write({1'b0, 3'h1, 1'b1, 1'b0, 3'h3, 1'b0, 3'h3});
    #1;
    chk(n_pulse, 1);
    repeat (180) tick;
    chk(dll_rdy, 1'b0);
    for (int k = 0; k < 40 && dll_rdy !== 1'b1; k++) tick;
    chk(dll_rdy, 1'b1);
    burst(3'h1, 8, 1'b0, 1'b0);
    burst(3'h5, 8, 1'b1, 1'b0);
    burst(3'h3, 4, 1'b0, 1'b1);
    burst(3'h2, 4, 1'b1, 1'b0);
    ctl.mode_write({1'b0, 3'h1, 2'h0, 3'h3, 1'b0, 3'h3});
    ctl.col_cmd(1'b0, 3'h0);
    repeat (2) @(posedge clk_in);
    ctl.col_cmd(1'b1, 3'h0);
    ctl.cmd(4'h6, 2'h0, 13'h0000);
    repeat (3) tick;
    chk(bact, 1'b1);
    chk(bwr, 1'b0);
    repeat (10) tick;
    chk(n_ill, 2);
    close_out;
  end
endmodule : tb_ddr2_mode_register_burst_order
`default_nettype wire
